// file: shared/alu_map.svh
// Purpose: Constants for the user-side AXI4-Lite access bridge.
// Assumes: Included by its bare name.
// Notes: Offsets are those of the small register window held by the slave end.
`ifndef ALU_MAP_SVH
`define ALU_MAP_SVH
`define ALU_RESP_OKAY 2'h0
`define ALU_RESP_EXOKAY 2'h1
`define ALU_RESP_SLVERR 2'h2
`define ALU_RESP_DECERR 2'h3
`define ALU_NUM_REGS 4
`define ALU_ADDR_LO 32'h0000_0000
`define ALU_ADDR_HI 32'h0000_000C
`define ALU_CTL_RESET 32'h0000_0000
`endif

// file: shared/alu_pkg.sv
// Purpose: Types for the user-side AXI4-Lite access bridge.
// Assumes: Nothing.
// Notes: Constants live in alu_map.svh.
package alu_pkg;
    typedef logic [31:0] alu_word_t;
    typedef logic [3:0] alu_strb_t;
    typedef logic [1:0] alu_resp_t;
    typedef enum logic [1:0] {
        ALU_IDLE,
        ALU_WRITE,
        ALU_READ,
        ALU_ACK
    } alu_state_t;
endpackage

// file: shared/alu_axil_if.sv
// Purpose: AXI4-Lite link between the user access machine and the register slave.
// Assumes: One clock and one reset shared by both ends.
// Notes: No clocking block; the testbench drives clock and reset.
`timescale 1ns/1ns
`default_nettype none
interface alu_axil_if;
    import alu_pkg::*;
    logic aclk;
    logic aresetn;
    alu_word_t awaddr;
    logic awvalid;
    logic awready;
    alu_word_t wdata;
    alu_strb_t wstrb;
    logic wvalid;
    logic wready;
    alu_resp_t bresp;
    logic bvalid;
    logic bready;
    alu_word_t araddr;
    logic arvalid;
    logic arready;
    alu_word_t rdata;
    alu_resp_t rresp;
    logic rvalid;
    logic rready;

    modport master (
        input aclk, aresetn,
        output awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready,
        input awready, wready, bresp, bvalid, arready, rdata, rresp, rvalid
    );
    modport slave (
        input aclk, aresetn,
        input awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready,
        output awready, wready, bresp, bvalid, arready, rdata, rresp, rvalid
    );
endinterface
`default_nettype wire

// file: verilog/alu_resp_check.sv
// Purpose: Classifies an AXI4-Lite response code as an error or not.
// Assumes: Response codes from the register slave.
// Notes: Only the slave-error code raises the error indication.
`timescale 1ns/1ns
`default_nettype none
module alu_resp_check
    import alu_pkg::*;
(
    input wire alu_resp_t resp_i, // Response code.
    output logic slverr_o // High when the code is a slave error.
);
`include "alu_map.svh"
    assign slverr_o = (resp_i == `ALU_RESP_SLVERR);
endmodule // alu_resp_check
`default_nettype wire

// file: verilog/alu_user_master.sv
// Purpose: User access machine turning single requests into AXI4-Lite transfers.
// Assumes: Requests and payload come from logic on the same clock.
// Notes: Reset is sampled synchronously on the AXI clock.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Idle after reset; read request starts read.
// - Write starts only without read; read wins.
// - Write phase drives address, data, strobes, valids.
// - Write ends on response valid and ready.
// - Slave-error write response raises write error.
// - Read phase drives read address and valid.
// - Read ends on read valid and ready.
// - Slave-error read response raises read error.
// - Acknowledge state always returns to idle.
// - Responses: OKAY, EXOKAY, SLVERR, DECERR codes.
// - Active-low reset sampled on AXI clock.
// - 32-bit address and data, 4-bit strobe.
// - Writes configure controls; reads return controls or status.
module alu_user_master
    import alu_pkg::*;
(
    alu_axil_if.master bus, // AXI4-Lite master side.
    input wire logic user_read_req_i, // Read request level.
    input wire logic user_write_req_i, // Write request level.
    input wire alu_word_t user_addr_i, // Register address.
    input wire alu_word_t user_wdata_i, // Write data.
    input wire alu_strb_t user_wstrb_i, // Write byte strobes.
    output alu_word_t user_rdata_o, // Last read data.
    output logic user_ack_o, // One-cycle done pulse.
    output logic user_busy_o, // High outside idle.
    output logic user_write_err_o, // Last write got slave error.
    output logic user_read_err_o // Last read got slave error.
);
`include "alu_map.svh"
    // ------------------------------------------------------------
    // State and channel registers
    // ------------------------------------------------------------
    alu_state_t state, next_state;
    logic awvalid, next_awvalid, wvalid, next_wvalid, arvalid, next_arvalid;
    alu_word_t addr, next_addr, wdata, next_wdata, rdata, next_rdata;
    alu_strb_t wstrb, next_wstrb;
    logic werr, next_werr, rerr, next_rerr;
    logic b_slverr, r_slverr;
    logic take_rd, take_wr;
    logic wr_done, rd_done;
    logic bready, rready;

    alu_resp_check u_bchk (.resp_i(bus.bresp), .slverr_o(b_slverr));
    alu_resp_check u_rchk (.resp_i(bus.rresp), .slverr_o(r_slverr));

    // ------------------------------------------------------------
    // Handshake decode
    // ------------------------------------------------------------
    // Requests are looked at only while idle, so a request raised mid-transfer is dropped.
    assign take_rd = (state == ALU_IDLE) && user_read_req_i;
    assign take_wr = (state == ALU_IDLE) && !user_read_req_i && user_write_req_i;
    // The response is accepted only once both write channels have been taken.
    assign bready = (state == ALU_WRITE) && !awvalid && !wvalid;
    assign rready = (state == ALU_READ) && !arvalid;
    assign wr_done = bus.bvalid && bready;
    assign rd_done = bus.rvalid && rready;

    // ------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            ALU_IDLE: begin
                if (take_rd) begin
                    next_state = ALU_READ;
                end else if (take_wr) begin
                    next_state = ALU_WRITE;
                end
            end
            ALU_WRITE: begin
                if (wr_done) begin
                    next_state = ALU_ACK;
                end
            end
            ALU_READ: begin
                if (rd_done) begin
                    next_state = ALU_ACK;
                end
            end
            ALU_ACK: begin
                next_state = ALU_IDLE;
            end
            default: begin
                next_state = ALU_IDLE;
            end
        endcase
    end

    always_ff @(posedge bus.aclk) begin
        if (!bus.aresetn) begin
            state <= ALU_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Channel valids
    // ------------------------------------------------------------
    // A valid drops only on the edge where its ready is seen, so a slow slave still gets it.
    always_comb begin
        next_awvalid = awvalid;
        next_wvalid = wvalid;
        next_arvalid = arvalid;
        if (take_wr) begin
            next_awvalid = 1'b1;
            next_wvalid = 1'b1;
        end
        if (take_rd) begin
            next_arvalid = 1'b1;
        end
        if (awvalid && bus.awready) begin
            next_awvalid = 1'b0;
        end
        if (wvalid && bus.wready) begin
            next_wvalid = 1'b0;
        end
        if (arvalid && bus.arready) begin
            next_arvalid = 1'b0;
        end
    end

    always_ff @(posedge bus.aclk) begin
        if (!bus.aresetn) begin
            awvalid <= 1'b0;
            wvalid <= 1'b0;
            arvalid <= 1'b0;
        end else begin
            awvalid <= next_awvalid;
            wvalid <= next_wvalid;
            arvalid <= next_arvalid;
        end
    end

    // ------------------------------------------------------------
    // Request payload
    // ------------------------------------------------------------
    // Payload is caught at the taking edge and held for the whole transfer.
    always_comb begin
        next_addr = addr;
        next_wdata = wdata;
        next_wstrb = wstrb;
        if (take_rd || take_wr) begin
            next_addr = user_addr_i;
        end
        if (take_wr) begin
            next_wdata = user_wdata_i;
            next_wstrb = user_wstrb_i;
        end
    end

    always_ff @(posedge bus.aclk) begin
        if (!bus.aresetn) begin
            addr <= '0;
            wdata <= '0;
            wstrb <= '0;
        end else begin
            addr <= next_addr;
            wdata <= next_wdata;
            wstrb <= next_wstrb;
        end
    end

    // ------------------------------------------------------------
    // Results
    // ------------------------------------------------------------
    // Error flags follow the response of the transfer that completes, and hold until the next.
    always_comb begin
        next_rdata = rdata;
        next_werr = werr;
        next_rerr = rerr;
        if (wr_done) begin
            next_werr = b_slverr;
        end
        if (rd_done) begin
            next_rdata = bus.rdata;
            next_rerr = r_slverr;
        end
    end

    always_ff @(posedge bus.aclk) begin
        if (!bus.aresetn) begin
            rdata <= '0;
            werr <= 1'b0;
            rerr <= 1'b0;
        end else begin
            rdata <= next_rdata;
            werr <= next_werr;
            rerr <= next_rerr;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign bus.awvalid = awvalid;
    assign bus.awaddr = addr;
    assign bus.wvalid = wvalid;
    assign bus.wdata = wdata;
    assign bus.wstrb = wstrb;
    assign bus.bready = bready;
    assign bus.arvalid = arvalid;
    assign bus.araddr = addr;
    assign bus.rready = rready;
    assign user_rdata_o = rdata;
    assign user_ack_o = (state == ALU_ACK);
    assign user_busy_o = (state != ALU_IDLE);
    assign user_write_err_o = werr;
    assign user_read_err_o = rerr;
endmodule // alu_user_master
`default_nettype wire

// file: verilog/alu_reg_slave.sv
// Purpose: AXI4-Lite register slave holding control words and returning status.
// Assumes: One outstanding transfer per channel.
// Notes: Addresses outside the window answer with a slave error.
`timescale 1ns/1ns
`default_nettype none
module alu_reg_slave
    import alu_pkg::*;
(
    alu_axil_if.slave bus, // AXI4-Lite slave side.
    input wire alu_word_t status_i, // Status word read at the top address.
    output alu_word_t ctl0_o, // Control word 0.
    output alu_word_t ctl1_o, // Control word 1.
    output alu_word_t ctl2_o // Control word 2.
);
`include "alu_map.svh"
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic logic legal(input alu_word_t a);
        legal = (a <= `ALU_ADDR_HI) && (a[1:0] == 2'h0);
    endfunction

    alu_word_t regs [`ALU_NUM_REGS-1:0];
    alu_word_t next_regs [`ALU_NUM_REGS-1:0];
    logic bvalid, next_bvalid, rvalid, next_rvalid;
    alu_resp_t bresp, next_bresp, rresp, next_rresp;
    alu_word_t rdata, next_rdata;
    logic do_wr, do_rd;

    assign do_wr = bus.awvalid && bus.wvalid && !bvalid;
    assign do_rd = bus.arvalid && !rvalid;

    always_comb begin
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rresp = rresp;
        next_rdata = rdata;
        for (int i = 0; i < `ALU_NUM_REGS; i++) begin
            next_regs[i] = regs[i];
        end
        if (bvalid && bus.bready) begin
            next_bvalid = 1'b0;
        end else if (do_wr) begin
            next_bvalid = 1'b1;
            if (legal(bus.awaddr) && bus.awaddr != `ALU_ADDR_HI) begin
                next_bresp = `ALU_RESP_OKAY;
                for (int b = 0; b < 4; b++) begin
                    if (bus.wstrb[b]) begin
                        next_regs[bus.awaddr[3:2]][8*b +: 8] = bus.wdata[8*b +: 8];
                    end
                end
            end else begin
                next_bresp = `ALU_RESP_SLVERR;
            end
        end
        if (rvalid && bus.rready) begin
            next_rvalid = 1'b0;
        end else if (do_rd) begin
            next_rvalid = 1'b1;
            if (legal(bus.araddr)) begin
                next_rresp = `ALU_RESP_OKAY;
                next_rdata = (bus.araddr == `ALU_ADDR_HI) ? status_i
                                                          : regs[bus.araddr[3:2]];
            end else begin
                next_rresp = `ALU_RESP_SLVERR;
                next_rdata = '0;
            end
        end
    end

    always_ff @(posedge bus.aclk) begin
        if (!bus.aresetn) begin
            bvalid <= 1'b0;
            bresp <= `ALU_RESP_OKAY;
            rvalid <= 1'b0;
            rresp <= `ALU_RESP_OKAY;
            rdata <= '0;
            for (int i = 0; i < `ALU_NUM_REGS; i++) begin
                regs[i] <= `ALU_CTL_RESET;
            end
        end else begin
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
            for (int i = 0; i < `ALU_NUM_REGS; i++) begin
                regs[i] <= next_regs[i];
            end
        end
    end

    assign bus.awready = do_wr;
    assign bus.wready = do_wr;
    assign bus.arready = do_rd;
    assign bus.bvalid = bvalid;
    assign bus.bresp = bresp;
    assign bus.rvalid = rvalid;
    assign bus.rresp = rresp;
    assign bus.rdata = rdata;
    assign ctl0_o = regs[0];
    assign ctl1_o = regs[1];
    assign ctl2_o = regs[2];
endmodule // alu_reg_slave
`default_nettype wire

// file: tb/alu_axil_sva.sv
// Purpose: Protocol checks on the AXI4-Lite link between the two ends.
// Assumes: One clock and an active-low reset.
// Notes: Instantiated beside the interface by the testbench.
`timescale 1ns/1ns
`default_nettype none
module alu_axil_sva
    import alu_pkg::*;
(
    input wire logic aclk, // Clock.
    input wire logic aresetn, // Reset, active low.
    input wire alu_word_t awaddr, // Write address.
    input wire logic awvalid, // Write address valid.
    input wire logic awready, // Write address ready.
    input wire logic wvalid, // Write data valid.
    input wire logic wready, // Write data ready.
    input wire alu_resp_t bresp, // Write response.
    input wire logic bvalid, // Write response valid.
    input wire logic bready, // Write response ready.
    input wire alu_word_t araddr, // Read address.
    input wire logic arvalid, // Read address valid.
    input wire logic arready, // Read address ready.
    input wire alu_resp_t rresp, // Read response.
    input wire logic rvalid, // Read data valid.
    input wire logic rready // Read ready.
);
`include "alu_map.svh"
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_wr_take;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence s_rd_take;
        arvalid && arready;
    endsequence
    property p_w_together;
        awvalid |-> wvalid;
    endproperty
    property p_wr_once;
        s_wr_take |=> !awvalid && !wvalid;
    endproperty
    property p_rd_once;
        s_rd_take |=> !arvalid;
    endproperty
    property p_wr_end;
        s_wr_take |=> (bvalid && bready) ##1 !bvalid;
    endproperty
    property p_rd_end;
        s_rd_take |=> (rvalid && rready) ##1 !rvalid;
    endproperty
    property p_wr_err;
        s_wr_take ##0 (awaddr >= `ALU_ADDR_HI || awaddr[1:0] != 2'h0) |=>
            bresp == `ALU_RESP_SLVERR;
    endproperty
    property p_rd_err;
        s_rd_take ##0 (araddr > `ALU_ADDR_HI || araddr[1:0] != 2'h0) |=>
            rresp == `ALU_RESP_SLVERR;
    endproperty
    property p_wr_hold;
        s_wr_take |=> $stable(awaddr);
    endproperty
    property p_rd_hold;
        s_rd_take |=> $stable(araddr);
    endproperty
    property p_one_dir;
        !(arvalid && (awvalid || wvalid));
    endproperty
    property p_ack_gap;
        rvalid && rready |=> (!arvalid && !awvalid) [*2];
    endproperty
    a_w_together: assert property (p_w_together) else $error("write valids apart");
    a_wr_once: assert property (p_wr_once) else $error("write valid held");
    a_rd_once: assert property (p_rd_once) else $error("read valid held");
    a_wr_end: assert property (p_wr_end) else $error("write response late");
    a_rd_end: assert property (p_rd_end) else $error("read data late");
    a_wr_err: assert property (p_wr_err) else $error("bad write not refused");
    a_rd_err: assert property (p_rd_err) else $error("bad read not refused");
    a_one_dir: assert property (p_one_dir) else $error("read and write overlap");
    a_ack_gap: assert property (p_ack_gap) else $error("no idle after ack");
    a_wr_hold: assert property (p_wr_hold) else $error("write address moved");
    a_rd_hold: assert property (p_rd_hold) else $error("read address moved");
endmodule // alu_axil_sva
`default_nettype wire

// file: tb/axi_lite_user_access_fsm_tb_top.sv
// Purpose: Self-checking bench for the access machine and register slave.
// Assumes: Inputs change on the falling clock edge.
// Notes: Status word is a fixed pattern.
`timescale 1ns/1ns
`default_nettype none
module axi_lite_user_access_fsm_tb_top;
    import alu_pkg::*;
    logic clk_sys_i;
    logic resetn_i;
    logic rd_req;
    logic wr_req;
    alu_word_t addr;
    alu_word_t wdata;
    alu_strb_t wstrb;
    alu_word_t rdata;
    alu_word_t ctl0;
    alu_word_t ctl1;
    alu_word_t ctl2;
    logic ack;
    logic busy;
    logic werr;
    logic rerr;
    int failures;
    int cmp_count;
    alu_axil_if bus ();
    assign bus.aclk = clk_sys_i;
    assign bus.aresetn = resetn_i;
    alu_user_master alu_user_master_inst (.bus(bus), .user_read_req_i(rd_req),
        .user_write_req_i(wr_req), .user_addr_i(addr), .user_wdata_i(wdata),
        .user_wstrb_i(wstrb), .user_rdata_o(rdata), .user_ack_o(ack), .user_busy_o(busy),
        .user_write_err_o(werr), .user_read_err_o(rerr));
    alu_reg_slave alu_reg_slave_inst (.bus(bus), .status_i(32'h5A5A_0001), .ctl0_o(ctl0),
        .ctl1_o(ctl1), .ctl2_o(ctl2));
    alu_axil_sva alu_axil_sva_inst (.aclk(bus.aclk), .aresetn(bus.aresetn),
        .awaddr(bus.awaddr), .awvalid(bus.awvalid), .awready(bus.awready),
        .wvalid(bus.wvalid), .wready(bus.wready), .bresp(bus.bresp), .bvalid(bus.bvalid),
        .bready(bus.bready), .araddr(bus.araddr), .arvalid(bus.arvalid),
        .arready(bus.arready), .rresp(bus.rresp), .rvalid(bus.rvalid), .rready(bus.rready));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input alu_word_t got, input alu_word_t exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // One request held for the taking edge, then the acknowledge pulse awaited.
    task automatic xfer(input logic rd, input logic wr, input alu_word_t a, input alu_word_t d,
                        input alu_strb_t s);
        int n;
        @(negedge clk_sys_i);
        rd_req = rd;
        wr_req = wr;
        addr = a;
        wdata = d;
        wstrb = s;
        @(negedge clk_sys_i);
        rd_req = 1'b0;
        wr_req = 1'b0;
        n = 0;
        while (ack !== 1'b1 && n < 20) begin
            @(negedge clk_sys_i);
            n++;
        end
        if (n == 20) begin
            failures++;
            finish_test();
        end
        @(negedge clk_sys_i);
        check({30'h0, ack, busy}, 32'h0);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_write_read();
        xfer(1'b0, 1'b1, 32'h0000_0004, 32'h1234_5678, 4'hF);
        check(ctl1, 32'h1234_5678);
        check({31'h0, werr}, 32'h0);
        xfer(1'b1, 1'b0, 32'h0000_0004, 32'h0, 4'h0);
        check(rdata, 32'h1234_5678);
        check({31'h0, rerr}, 32'h0);
        $display("t_write_read done");
    endtask
    task automatic t_strobe();
        xfer(1'b0, 1'b1, 32'h0000_0008, 32'hFFFF_FFFF, 4'hF);
        xfer(1'b0, 1'b1, 32'h0000_0008, 32'hAABB_CCDD, 4'h5);
        check(ctl2, 32'hFFBB_FFDD);
        $display("t_strobe done");
    endtask
    task automatic t_illegal();
        xfer(1'b0, 1'b1, 32'h0000_0010, 32'hDEAD_BEEF, 4'hF);
        check({31'h0, werr}, 32'h1);
        xfer(1'b0, 1'b1, 32'h0000_0004, 32'h1234_5678, 4'hF);
        check({31'h0, werr}, 32'h0);
        xfer(1'b0, 1'b1, 32'h0000_000C, 32'hDEAD_BEEF, 4'hF);
        check({31'h0, werr}, 32'h1);
        check(ctl1, 32'h1234_5678);
        xfer(1'b1, 1'b0, 32'h0000_0002, 32'h0, 4'h0);
        check({31'h0, rerr}, 32'h1);
        xfer(1'b1, 1'b0, 32'h0000_000C, 32'h0, 4'h0);
        check(rdata, 32'h5A5A_0001);
        check({31'h0, rerr}, 32'h0);
        $display("t_illegal done");
    endtask
    // Both requests at once: only the read runs, the write is not kept.
    task automatic t_priority();
        xfer(1'b1, 1'b1, 32'h0000_0000, 32'hFFFF_0000, 4'hF);
        repeat (6) @(negedge clk_sys_i);
        check(ctl0, 32'h0);
        check(rdata, 32'h0);
        $display("t_priority done");
    endtask
    // A write raised while a read runs is dropped, not queued.
    task automatic t_busy_ignore();
        @(negedge clk_sys_i);
        rd_req = 1'b1;
        addr = 32'h0000_0000;
        wdata = 32'h0000_BEEF;
        wstrb = 4'hF;
        @(negedge clk_sys_i);
        rd_req = 1'b0;
        wr_req = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        wr_req = 1'b0;
        check({31'h0, ack}, 32'h1);
        repeat (4) @(negedge clk_sys_i);
        check(ctl0, 32'h0);
        check({31'h0, busy}, 32'h0);
        $display("t_busy_ignore done");
    endtask
    task automatic t_reset();
        @(negedge clk_sys_i);
        wr_req = 1'b1;
        addr = 32'h0000_0000;
        @(negedge clk_sys_i);
        wr_req = 1'b0;
        resetn_i = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        check({31'h0, busy}, 32'h0);
        check(ctl1, 32'h0);
        resetn_i = 1'b1;
        xfer(1'b1, 1'b0, 32'h0000_0008, 32'h0, 4'h0);
        check(rdata, 32'h0);
        $display("t_reset done");
    endtask
    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        failures = 0;
        cmp_count = 0;
        resetn_i = 1'b0;
        rd_req = 1'b0;
        wr_req = 1'b0;
        addr = 32'h0;
        wdata = 32'h0;
        wstrb = 4'h0;
        repeat (12) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        resetn_i = 1'b1;
        check({31'h0, busy}, 32'h0);
        t_write_read();
        t_strobe();
        t_illegal();
        t_priority();
        t_busy_ignore();
        t_reset();
        finish_test();
    end
endmodule // axi_lite_user_access_fsm_tb_top
`default_nettype wire
